// file: logic/flc_defines.vh
// constants for the flash lock and protection-store command controller
// Function
// - host suspends erase with B0, polls status, locks, then resumes with D0.
// - protection program is C0 then one address/data write of 16 bits.
// - user segment locks by programming FFFD to the protection lock word.
// - host never aims protection writes outside the protection store range.
// - unlock is 60 then D0, clearing the addressed block's lock bit unless the block is locked down.
// - lock-down is 60 then 2F, setting lock-down and lock bits.
`ifndef FLC_DEFINES_VH
`define FLC_DEFINES_VH
`define FLC_CMD_READ_ARRAY 8'hFF
`define FLC_CMD_READ_STATUS 8'h70
`define FLC_CMD_CLEAR_STATUS 8'h50
`define FLC_CMD_READ_ID 8'h90
`define FLC_CMD_LOCK_SETUP 8'h60
`define FLC_CMD_LOCK 8'h01
`define FLC_CMD_UNLOCK 8'hD0
`define FLC_CMD_LOCKDOWN 8'h2F
`define FLC_CMD_PROT_SETUP 8'hC0
`define FLC_CMD_SUSPEND 8'hB0
`define FLC_CMD_RESUME 8'hD0
`define FLC_PROT_LOCK_VALUE 16'hFFFD
`define FLC_LOCK_STATUS_OFS 22'h000002
// protection store window: lock word then eight data words
`define FLC_PROT_BASE 22'h000080
`define FLC_PROT_LAST 22'h000088
// software-facing register offsets
`define FLC_REG_CTRL 4'h0
`define FLC_REG_ADDR 4'h1
`define FLC_REG_DATA 4'h2
`define FLC_REG_STATUS 4'h3
`define FLC_REG_RDATA 4'h4
// operation codes written to the control register, bits 2:0
`define FLC_OP_LOCK 3'h1
`define FLC_OP_UNLOCK 3'h2
`define FLC_OP_LOCKDOWN 3'h3
`define FLC_OP_PROT_PROG 3'h4
`define FLC_OP_PROT_LOCK 3'h5
`define FLC_OP_READ_ID 3'h6
`define FLC_OP_SUSP_LOCK 3'h7
// status word bit positions on the device
`define FLC_SR_READY 7
`define FLC_SR_ERASE_ERR 5
`define FLC_SR_PROG_ERR 4
`define FLC_SR_SUPPLY_ERR 3
`define FLC_SR_LOCK_ERR 1
`define FLC_SR_SUSPENDED 6
// bus cycle timing: final count of each strobe phase; a phase lasts four cycles
`define FLC_T_PHASE 4'h3
`define FLC_SEQ_LEN 4'h8
`endif

// file: logic/flc_seq_mem.v
// small command sequence memory: holds the writes of one flash sequence
`timescale 1ns/1ps
module flc_seq_mem (
	input wire mclk, // system clock
	input wire ce, // clock enable
	input wire we, // write strobe
	input wire [2:0] waddr, // write index
	input wire [38:0] wdata, // {is_read, addr22, data16}
	input wire [2:0] raddr, // read index
	output reg [38:0] rdata_r // registered read data
);
	reg [38:0] mem [0:7];
	always @(posedge mclk) begin
		if (ce) begin
			if (we)
				mem[waddr] <= wdata;
			rdata_r <= mem[raddr];
		end
	end
endmodule // flc_seq_mem

// file: logic/flc_ctrl.v
// host controller that drives flash lock and protection-store command sequences
`timescale 1ns/1ps
`include "flc_defines.vh"
module flc_ctrl (
	input wire mclk, // 50 MHz clock
	input wire reset, // synchronous, active high
	input wire ce, // clock enable
	input wire [3:0] sw_addr, // register address
	input wire [31:0] sw_wdata, // register write data
	input wire sw_wr, // write strobe
	input wire sw_rd, // read strobe
	output reg [31:0] sw_rdata_r, // read data, one cycle later
	output reg [21:0] fl_addr_r, // flash address
	output reg [15:0] fl_dq_out_r, // flash data out
	output reg fl_dq_oe_r, // flash data drive enable
	input wire [15:0] fl_dq_in, // flash data in
	output reg fl_ce_n_r, // flash chip enable, low active
	output reg fl_we_n_r, // flash write enable, low active
	output reg fl_oe_n_r // flash output enable, low active
);
	localparam ST_IDLE = 3'd0;
	localparam ST_LOAD = 3'd1;
	localparam ST_SETUP = 3'd2;
	localparam ST_STROBE = 3'd3;
	localparam ST_HOLD = 3'd4;
	localparam ST_NEXT = 3'd5;
	localparam ST_POLL = 3'd6;

	reg [2:0] state_r, state_nxt;
	reg [2:0] op_r;
	reg [21:0] addr_r;
	reg [15:0] data_r;
	reg busy_r, lock_err_r, prog_err_r, erase_err_r, supply_err_r, done_r;
	reg [15:0] rd_r;
	reg [3:0] tcnt_r;
	reg [2:0] idx_r, len_r, widx_r;
	reg [2:0] wa_r;
	reg we_r;
	reg [38:0] wd_r;
	wire [38:0] ent;

	flc_seq_mem u_mem (
		.mclk(mclk),
		.ce(ce),
		.we(we_r),
		.waddr(wa_r),
		.wdata(wd_r),
		.raddr(idx_r),
		.rdata_r(ent)
	);

	// one bus write entry; is_read bit 38 clear
	function [38:0] wr_ent;
		input [21:0] a;
		input [7:0] c;
		begin
			wr_ent = {1'b0, a, 8'h00, c};
		end
	endfunction

	// build the write list of an operation, entry k
	function [38:0] seq_ent;
		input [2:0] op;
		input [2:0] k;
		input [21:0] a;
		input [15:0] d;
		begin
			seq_ent = wr_ent(a, `FLC_CMD_READ_ARRAY);
			case (op)
			`FLC_OP_LOCK, `FLC_OP_UNLOCK, `FLC_OP_LOCKDOWN: begin
				if (k == 3'd0)
					seq_ent = wr_ent(a, `FLC_CMD_LOCK_SETUP);
				else if (k == 3'd1)
					seq_ent = wr_ent(a, (op == `FLC_OP_LOCK) ? `FLC_CMD_LOCK :
						(op == `FLC_OP_UNLOCK) ? `FLC_CMD_UNLOCK :
						`FLC_CMD_LOCKDOWN);
				else
					seq_ent = {1'b1, a, 16'h0000};
			end
			`FLC_OP_SUSP_LOCK: begin
				// suspend, poll, lock, then resume
				if (k == 3'd0)
					seq_ent = wr_ent(a, `FLC_CMD_SUSPEND);
				else if (k == 3'd1)
					seq_ent = {1'b1, a, 16'h0001}; // poll for suspend
				else if (k == 3'd2)
					seq_ent = wr_ent(a, `FLC_CMD_LOCK_SETUP);
				else if (k == 3'd3)
					seq_ent = wr_ent(a, d[7:0]);
				else if (k == 3'd4)
					seq_ent = wr_ent(a, `FLC_CMD_RESUME);
				else
					seq_ent = {1'b1, a, 16'h0000};
			end
			`FLC_OP_PROT_PROG, `FLC_OP_PROT_LOCK: begin
				if (k == 3'd0)
					seq_ent = wr_ent(a, `FLC_CMD_PROT_SETUP);
				else if (k == 3'd1)
					seq_ent = {1'b0, a, (op == `FLC_OP_PROT_LOCK) ?
						`FLC_PROT_LOCK_VALUE : d};
				else
					seq_ent = {1'b1, a, 16'h0000};
			end
			`FLC_OP_READ_ID: begin
				if (k == 3'd0)
					seq_ent = wr_ent(a, `FLC_CMD_READ_ID);
				else if (k == 3'd1)
					seq_ent = {1'b1, a, 16'h0002}; // data read, no poll
				else if (k == 3'd2)
					seq_ent = wr_ent(a, `FLC_CMD_READ_ARRAY);
				else
					seq_ent = {1'b1, a, 16'h0000};
			end
			default: seq_ent = {1'b1, a, 16'h0000};
			endcase
		end
	endfunction

	function [2:0] seq_len;
		input [2:0] op;
		begin
			case (op)
			`FLC_OP_SUSP_LOCK: seq_len = 3'd6;
			`FLC_OP_READ_ID: seq_len = 3'd3;
			default: seq_len = 3'd3;
			endcase
		end
	endfunction

	wire ent_rd = ent[38];
	wire [1:0] ent_kind = ent[1:0];
	wire phase_end = (tcnt_r == `FLC_T_PHASE);
	wire [2:0] idx_inc = idx_r + 3'd1;
	wire last_ent = (idx_inc == len_r);
	// status is undefined after a protection write outside the store, so never start one
	wire prot_op = (sw_wdata[2:0] == `FLC_OP_PROT_PROG) ||
		(sw_wdata[2:0] == `FLC_OP_PROT_LOCK);
	wire prot_bad = prot_op && ((addr_r < `FLC_PROT_BASE) || (addr_r > `FLC_PROT_LAST));

	always @* begin
		state_nxt = state_r;
		case (state_r)
		ST_IDLE: if (busy_r) state_nxt = ST_LOAD;
		ST_LOAD: if (widx_r == len_r) state_nxt = ST_SETUP;
		ST_SETUP: if (phase_end) state_nxt = ST_STROBE;
		ST_STROBE: if (phase_end) state_nxt = ST_HOLD;
		ST_HOLD: if (phase_end) state_nxt = ST_NEXT;
		ST_NEXT: state_nxt = last_ent ? ST_IDLE : ST_SETUP;
		ST_POLL: state_nxt = ST_SETUP;
		default: state_nxt = ST_IDLE;
		endcase
	end

	always @(posedge mclk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			op_r <= 3'd0;
			addr_r <= 22'h000000;
			data_r <= 16'h0000;
			busy_r <= 1'b0;
			done_r <= 1'b0;
			lock_err_r <= 1'b0;
			prog_err_r <= 1'b0;
			erase_err_r <= 1'b0;
			supply_err_r <= 1'b0;
			rd_r <= 16'h0000;
			tcnt_r <= 4'h0;
			idx_r <= 3'd0;
			len_r <= 3'd0;
			widx_r <= 3'd0;
			wa_r <= 3'd0;
			we_r <= 1'b0;
			wd_r <= 39'h0;
			sw_rdata_r <= 32'h0;
			fl_addr_r <= 22'h0;
			fl_dq_out_r <= 16'h0;
			fl_dq_oe_r <= 1'b0;
			fl_ce_n_r <= 1'b1;
			fl_we_n_r <= 1'b1;
			fl_oe_n_r <= 1'b1;
		end else if (ce) begin
			state_r <= state_nxt;
			we_r <= 1'b0;
			sw_rdata_r <= 32'h0;
			if (sw_wr && !busy_r) begin
				case (sw_addr)
				`FLC_REG_CTRL: begin
					op_r <= sw_wdata[2:0];
					busy_r <= (sw_wdata[2:0] != 3'd0) && !prot_bad;
					done_r <= prot_bad;
					widx_r <= 3'd0;
					len_r <= seq_len(sw_wdata[2:0]);
				end
				`FLC_REG_ADDR: addr_r <= sw_wdata[21:0];
				`FLC_REG_DATA: data_r <= sw_wdata[15:0];
				default: ;
				endcase
			end
			if (sw_rd) begin
				case (sw_addr)
				`FLC_REG_CTRL: sw_rdata_r <= {29'h0, op_r};
				`FLC_REG_ADDR: sw_rdata_r <= {10'h0, addr_r};
				`FLC_REG_DATA: sw_rdata_r <= {16'h0, data_r};
				`FLC_REG_STATUS: sw_rdata_r <= {26'h0, supply_err_r, lock_err_r,
					erase_err_r, prog_err_r, done_r, busy_r};
				`FLC_REG_RDATA: sw_rdata_r <= {16'h0, rd_r};
				default: sw_rdata_r <= 32'h0;
				endcase
			end
			case (state_r)
			ST_LOAD: begin
				// sequence built one entry a cycle into the memory
				we_r <= (widx_r != len_r);
				wd_r <= seq_ent(op_r, widx_r, addr_r, data_r);
				// write address staged with the data so entry k lands in word k
				wa_r <= widx_r;
				if (widx_r != len_r)
					widx_r <= widx_r + 3'd1;
				idx_r <= 3'd0;
				tcnt_r <= 4'h0;
			end
			ST_SETUP: begin
				tcnt_r <= phase_end ? 4'h0 : tcnt_r + 4'h1;
				fl_addr_r <= ent[37:16];
				fl_ce_n_r <= 1'b0;
				fl_dq_oe_r <= !ent_rd;
				fl_dq_out_r <= ent[15:0];
			end
			ST_STROBE: begin
				tcnt_r <= phase_end ? 4'h0 : tcnt_r + 4'h1;
				fl_we_n_r <= ent_rd;
				fl_oe_n_r <= !ent_rd;
			end
			ST_HOLD: begin
				tcnt_r <= phase_end ? 4'h0 : tcnt_r + 4'h1;
				if (fl_oe_n_r == 1'b0 && tcnt_r == 4'h0)
					rd_r <= fl_dq_in;
				fl_we_n_r <= 1'b1;
				fl_oe_n_r <= 1'b1;
			end
			ST_NEXT: begin
				fl_ce_n_r <= 1'b1;
				fl_dq_oe_r <= 1'b0;
				// a poll entry repeats until ready and suspended bits both show
				if (ent_rd && ent_kind == 2'd1 &&
					!(rd_r[`FLC_SR_READY] && rd_r[`FLC_SR_SUSPENDED])) begin
					idx_r <= idx_r;
				end else if (ent_rd && ent_kind == 2'd0 && last_ent) begin
					// final status read: copy error bits back
					prog_err_r <= rd_r[`FLC_SR_PROG_ERR];
					erase_err_r <= rd_r[`FLC_SR_ERASE_ERR];
					lock_err_r <= rd_r[`FLC_SR_LOCK_ERR];
					supply_err_r <= rd_r[`FLC_SR_SUPPLY_ERR];
					idx_r <= idx_inc;
				end else begin
					idx_r <= idx_inc;
				end
				if (last_ent) begin
					busy_r <= 1'b0;
					done_r <= 1'b1;
				end
			end
			default: ;
			endcase
		end
	end
endmodule // flc_ctrl

// file: bench/flc_ctrl_asserts.sv
// pin-level checks on the flash side of the lock controller and on its idle read data
`timescale 1ns/1ps
module flc_ctrl_asserts (
	input wire mclk, // clock
	input wire reset, // sync reset
	input wire sw_rd, // read strobe
	input wire [31:0] sw_rdata_r, // read data
	input wire [21:0] fl_addr_r, // flash address
	input wire fl_dq_oe_r, // data drive
	input wire fl_ce_n_r, // chip enable
	input wire fl_we_n_r, // write enable
	input wire fl_oe_n_r // output enable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	property p_we_len; $fell(fl_we_n_r) |-> !fl_we_n_r[*4] ##1 fl_we_n_r; endproperty
	a_we_len: assert property (p_we_len) else $error("write pulse width");
	property p_oe_len; $fell(fl_oe_n_r) |-> !fl_oe_n_r[*4] ##1 fl_oe_n_r; endproperty
	a_oe_len: assert property (p_oe_len) else $error("read pulse width");
	property p_ce_first; $fell(fl_we_n_r) |-> !$past(fl_ce_n_r); endproperty
	a_ce_first: assert property (p_ce_first) else $error("select late");
	property p_ce_hold; $rose(fl_we_n_r) |-> !fl_ce_n_r; endproperty
	a_ce_hold: assert property (p_ce_hold) else $error("select dropped early");
	property p_we_data; !fl_we_n_r |-> fl_dq_oe_r && $stable(fl_addr_r); endproperty
	a_we_data: assert property (p_we_data) else $error("write data unstable");
	property p_no_fight; !fl_oe_n_r |-> !fl_dq_oe_r && !fl_ce_n_r; endproperty
	a_no_fight: assert property (p_no_fight) else $error("bus fight");
	property p_one_strobe; fl_we_n_r || fl_oe_n_r; endproperty
	a_one_strobe: assert property (p_one_strobe) else $error("both strobes low");
	property p_rd_idle; !$past(sw_rd) |-> sw_rdata_r == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
endmodule // flc_ctrl_asserts

// file: bench/flc_flash_model.sv
// behavioural flash device: lock bits, status word, protection store
`timescale 1ns/1ps
module flc_flash_model #(parameter logic [21:0] PB = 22'h000080) (
	input wire fl_ce_n, // chip enable
	input wire fl_we_n, // write enable
	input wire fl_oe_n, // output enable
	input wire [21:0] fl_addr, // address
	input wire [15:0] fl_d, // bus level
	input wire erase_run, // erase under way
	input wire program_supply_lockout_level, // supply too low
	output wire [15:0] fl_q // device data
);
	logic [1:0] lk [64];
	logic [15:0] pr [9];
	logic [5:0] sr = 6'h0;
	logic [2:0] md = 3'h0;
	logic sus = 1'b0;
	logic [15:0] q;
	logic [15:0] lq = 16'h0;
	wire [5:0] b = fl_addr[20:15];
	wire [21:0] i = fl_addr - PB;
	initial begin
		foreach (lk[n]) lk[n] = 2'h1;
		foreach (pr[n]) pr[n] = 16'hFFFF;
		pr[0] = 16'hFFFE;
	end
	always @(posedge fl_we_n) if (!fl_ce_n) begin
		if (md == 3) begin
			md = 1;
			if (fl_d[7:0] == 8'h01) lk[b][0] = 1;
			else if (fl_d[7:0] == 8'hD0) lk[b][0] = lk[b][1];
			else if (fl_d[7:0] == 8'h2F) lk[b] = 2'h3;
			else sr[5:4] = 2'h3;
		end else if (md == 4) begin
			md = 1;
			if (program_supply_lockout_level) sr[4:3] = 2'h3;
			else if (i > 8 || (i != 0 && !pr[0][i > 4])) sr = sr | 6'h12;
			else pr[i[3:0]] = pr[i[3:0]] & fl_d;
		end else case (fl_d[7:0])
			8'hFF: md = 0;
			8'h50: begin
				sr = 0;
				md = 0;
			end
			8'h90: md = 2;
			8'h60: md = 3;
			8'hC0: md = 4;
			8'hB0: if (erase_run) begin
				sus = 1;
				md = 1;
			end
			8'hD0: sus = 0;
			default: md = 1;
		endcase
	end
	always @* begin
		q = fl_addr[15:0];
		if (md == 2) q = (i < 9) ? pr[i[3:0]] :
			(fl_addr[14:0] == 15'h2) ? {14'h0, lk[b]} : 16'h0;
		else if (md != 0) q = {8'h0, !(erase_run && !sus), sus, sr};
	end
	// released bus shows the inverse so a stale value never passes
	always @(posedge fl_oe_n) lq <= q;
	assign fl_q = (!fl_ce_n && !fl_oe_n) ? q : ~lq;
endmodule // flc_flash_model

// file: bench/test_flc_ctrl.sv
// testbench for the flash lock command controller
`timescale 1ns/1ps
module test_flc_ctrl;
	localparam logic [21:0] PB = 22'h000080;
	logic mclk = 0, reset = 1, sw_wr = 0, sw_rd = 0, er = 0, vl = 0;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0, d;
	wire [31:0] sw_rdata_r;
	wire [21:0] fa;
	wire [15:0] fo, fq;
	wire foe, fce, fwe, fre;
	wire [15:0] w = foe ? fo : fq;
	int n_errors = 0, total_checks = 0;
	flc_ctrl DUT (.mclk(mclk), .reset(reset), .ce(1'b1), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
		.sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r), .fl_addr_r(fa), .fl_dq_out_r(fo),
		.fl_dq_oe_r(foe), .fl_dq_in(w), .fl_ce_n_r(fce), .fl_we_n_r(fwe), .fl_oe_n_r(fre));
	flc_flash_model #(.PB(PB)) u_mem (.fl_ce_n(fce), .fl_we_n(fwe), .fl_oe_n(fre), .fl_addr(fa),
		.fl_d(w), .erase_run(er), .program_supply_lockout_level(vl), .fl_q(fq));
	initial forever #10 mclk = ~mclk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		sw_addr <= a;
		sw_wdata <= v;
		sw_wr <= 1;
		@(posedge mclk);
		sw_wr <= 0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		sw_addr <= a;
		sw_rd <= 1;
		@(posedge mclk);
		sw_rd <= 0;
		@(posedge mclk);
		d = sw_rdata_r;
	endtask
	// leaves the final status word in d
	task automatic op(input logic [21:0] a, input logic [15:0] v, input logic [2:0] o);
		wr(4'h1, {10'h0, a});
		wr(4'h2, {16'h0, v});
		wr(4'h0, {29'h0, o});
		repeat (400) begin
			rd(4'h3);
			if (d[1] === 1'b1) break;
		end
		chk(d[1], 1'b1);
	endtask
	task automatic idr(input logic [21:0] a);
		op(a, 16'h0, 3'h6);
		rd(4'h4);
	endtask
	task automatic t_reset_state;
		idr(22'h2);
		chk(d[1:0], 2'h1);
	endtask
	task automatic t_lock_cmds;
		logic [2:0] ops [4] = '{3'h2, 3'h1, 3'h3, 3'h2};
		logic [1:0] ex [4] = '{2'h0, 2'h1, 2'h3, 2'h3};
		for (int k = 0; k < 4; k++) begin
			op(22'h8000, 16'h0, ops[k]);
			idr(22'h8002);
			chk(d[1:0], ex[k]);
		end
	endtask
	task automatic t_suspend;
		er <= 1;
		op(22'h10000, 16'h00D0, 3'h7);
		chk(d[3:2], 2'h0);
		idr(22'h10002);
		chk(d[1:0], 2'h0);
		op(22'h10000, 16'h0055, 3'h7);
		chk(d[3:2], 2'h3);
		er <= 0;
	endtask
	task automatic t_prot;
		op(PB + 9, 16'h0, 3'h4);
		chk(d[4], 1'b0);
		op(PB + 5, 16'h1234, 3'h4);
		idr(PB + 5);
		chk(d[15:0], 16'h1234);
		op(PB, 16'h0, 3'h5);
		idr(PB);
		chk(d[15:0], 16'hFFFC);
		op(PB + 5, 16'h0, 3'h4);
		chk(d[4], 1'b1);
		idr(PB + 5);
		chk(d[15:0], 16'h1234);
	endtask
	task automatic t_supply;
		vl <= 1;
		op(PB + 6, 16'h0, 3'h4);
		chk(d[5], 1'b1);
	endtask
	task automatic complete_run;
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge mclk);
		reset <= 0;
		t_reset_state();
		t_lock_cmds();
		t_suspend();
		t_prot();
		t_supply();
		complete_run();
	end
	initial begin
		#1000000;
		n_errors++;
		complete_run();
	end
endmodule // test_flc_ctrl
bind flc_ctrl flc_ctrl_asserts u_chk (.mclk(mclk), .reset(reset), .sw_rd(sw_rd),
	.sw_rdata_r(sw_rdata_r), .fl_addr_r(fl_addr_r), .fl_dq_oe_r(fl_dq_oe_r),
	.fl_ce_n_r(fl_ce_n_r), .fl_we_n_r(fl_we_n_r), .fl_oe_n_r(fl_oe_n_r));
